// ===== rtcw_consts.vh
`ifndef RTCW_CONSTS_VH
`define RTCW_CONSTS_VH
// ---------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------
`define RTCW_A_CTRL   6'h00
`define RTCW_A_TIMER  6'h04
`define RTCW_A_WDOG   6'h08
`define RTCW_A_CAL    6'h0C
`define RTCW_A_ALM1   6'h10
`define RTCW_A_ALM2   6'h14
`define RTCW_A_FLAGS  6'h18
`define RTCW_A_TIME   6'h1C
`define RTCW_A_ISTAT  6'h20
`define RTCW_A_IMASK  6'h24
// ---------------------------------------------------------
// control register fields
// ---------------------------------------------------------
`define RTCW_C_TRUN   0
`define RTCW_C_TIE    1
`define RTCW_C_TPUL   2
`define RTCW_C_M1IE   3
`define RTCW_C_M2EN   4
`define RTCW_C_M2IE   5
`define RTCW_C_OSCILLATOR_FAIL_IRQ_ENABLE   6
`define RTCW_C_HALT   7
`define RTCW_C_FT     8
`define RTCW_C_SQEN   9
`define RTCW_C_SQSL   11:10
`define RTCW_C_TSRC   13:12
`define RTCW_CTRL_W   14
`define RTCW_CTRL_RST 14'h0080
// ---------------------------------------------------------
// flag / status bit positions
// ---------------------------------------------------------
`define RTCW_F_ROLL   0
`define RTCW_F_WDG    1
`define RTCW_F_M1     2
`define RTCW_F_M2     3
`define RTCW_F_OF     4
`define RTCW_NFLAG    5
`define RTCW_F_COR    5'h0F
// ---------------------------------------------------------
// watchdog and calibration fields
// ---------------------------------------------------------
`define RTCW_W_MULT   4:0
`define RTCW_W_RES    6:5
`define RTCW_K_MAG    4:0
`define RTCW_K_SIGN   5
// ---------------------------------------------------------
// timing
// ---------------------------------------------------------
`define RTCW_PULSE_NS 128
`define RTCW_CLK_NS   8
`endif

// ===== rtcw_top.v
// Notes on behaviour
// - 8-bit countdown to 1, then auto reload
// - timer reloads start value while run enable clear
// - wrap sets rollover flag; flag read clears
// - timer irq enable routes rollover to irq one
// - mode bit picks level or pulse timer irq
// - watchdog period is resolution times multiplier
// - expiry sets flag and drives irq one
// - only watchdog write releases; zero disables
// - first match sets flag, optional irq one
// - second match needs enable; irq to two
// - second match flag drives irq two only with its irq enable
// - flag read reports then clears match flags
// - oscillator fail flag cleared only by write
// - calibration: 5-bit magnitude plus sign
// - power-down sets halt; time reads frozen
// - frequency test only with no irq enabled
// - square wave toggles only while enabled
//
// The AHB-Lite register port and the register offsets were chosen for this implementation.
`include "rtcw_consts.vh"
module rtcw_top #(
  parameter PULSE_CYC = `RTCW_PULSE_NS / `RTCW_CLK_NS
) (
  input  wire        clk_i,
  input  wire        nrst_i,
  input  wire        hsel_i,
  input  wire [31:0] haddr_i,
  input  wire [1:0]  htrans_i,
  input  wire        hwrite_i,
  input  wire [2:0]  hsize_i,
  input  wire [31:0] hwdata_i,
  input  wire        hready_i,
  output reg  [31:0] hrdata_o,
  output reg         hreadyout_o,
  output reg         hresp_o,
  input  wire [3:0]  tick_src_i,
  input  wire [31:0] time_i,
  input  wire        power_down_i,
  input  wire        osc_fail_i,
  output reg  [31:0] time_snap_o,
  output reg         time_halt_o,
  output reg  [4:0]  cal_mag_o,
  output reg         cal_neg_o,
  output reg         sqw_o,
  output reg         freq_test_o,
  output reg         interrupt_out_one_o,
  output reg         interrupt_out_one_oe_o,
  output reg         interrupt_out_two_o,
  output reg         interrupt_out_two_oe_o,
  output reg         irq_o
);
  // ---------------------------------------------------------
  // helpers
  // ---------------------------------------------------------
  // pick one tick strobe from the four sources
  function pick_tick;
    input [3:0] src;
    input [1:0] sel;
    begin
      pick_tick = src[sel];
    end
  endfunction

  // ---------------------------------------------------------
  // state
  // ---------------------------------------------------------
  reg [`RTCW_CTRL_W-1:0] ctrl_reg;     // control bits
  reg [7:0]              tstart_reg;   // timer start value
  reg [7:0]              tcnt_reg;     // timer count
  reg [6:0]              wdog_reg;     // mult and resolution
  reg [4:0]              wcnt_reg;     // watchdog countdown
  reg                    wlatch_reg;   // watchdog irq hold
  reg [5:0]              cal_reg;      // calibration
  reg [31:0]             alm1_reg;     // first match value
  reg [31:0]             alm2_reg;     // second match value
  reg                    m1_prev_reg;  // match edge history
  reg                    m2_prev_reg;
  reg [`RTCW_NFLAG-1:0]  flag_reg;     // flag register
  reg [`RTCW_NFLAG-1:0]  istat_reg;    // sticky status
  reg [`RTCW_NFLAG-1:0]  imask_reg;    // status mask
  reg [7:0]              pcnt_reg;     // pulse-mode timer
  reg                    ftog_reg;     // test toggle
  // bus address-phase capture
  reg [5:0]              addr_reg;
  reg                    wr_pend_reg;
  reg                    rd_pend_reg;

  // ---------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------
  wire acc    = hsel_i & htrans_i[1] & hready_i;
  wire wr_en  = wr_pend_reg;
  wire [5:0] wa = addr_reg;
  // only word offsets inside the map answer with data
  wire a_hit  = (haddr_i[31:6] == 26'h0);

  // ---------------------------------------------------------
  // event sources
  // ---------------------------------------------------------
  wire t_tick = pick_tick(tick_src_i, ctrl_reg[`RTCW_C_TSRC]);
  wire w_tick = pick_tick(tick_src_i, wdog_reg[`RTCW_W_RES]);
  wire s_tick = pick_tick(tick_src_i, ctrl_reg[`RTCW_C_SQSL]);
  // wrap from 1 back to start value
  wire roll   = ctrl_reg[`RTCW_C_TRUN] & t_tick &
                (tcnt_reg == 8'h01);
  // expiry after mult resolution ticks
  wire w_arm  = (wdog_reg[`RTCW_W_MULT] != 5'h00);
  wire w_exp  = w_arm & w_tick & (wcnt_reg == 5'h01);
  // match taken on its rising edge, one event per match
  wire m1_now = (time_i == alm1_reg);
  wire m2_now = (time_i == alm2_reg);
  wire m1_set = m1_now & ~m1_prev_reg;
  wire m2_set = m2_now & ~m2_prev_reg &
                ctrl_reg[`RTCW_C_M2EN];
  wire [`RTCW_NFLAG-1:0] ev = {osc_fail_i, m2_set, m1_set,
                               w_exp, roll};
  // host read of the flag register in this cycle
  wire f_rd  = rd_pend_reg & (addr_reg == `RTCW_A_FLAGS);
  // host write of the flag register
  wire f_wr  = wr_en & (wa == `RTCW_A_FLAGS);
  wire w_wr  = wr_en & (wa == `RTCW_A_WDOG);

  // ---------------------------------------------------------
  // combinational next values
  // ---------------------------------------------------------
  reg [`RTCW_NFLAG-1:0] flag_next;
  reg [`RTCW_NFLAG-1:0] istat_next;
  reg [31:0]            rdata_next;
  reg                   interrupt_out_one_next;
  reg                   interrupt_out_two_next;
  reg                   ft_next;

  // flags: set beats any clear in the same cycle
  always @* begin
    flag_next = flag_reg;
    if (f_rd) begin
      flag_next = flag_next & ~`RTCW_F_COR;
    end
    if (f_wr && !hwdata_i[`RTCW_F_OF]) begin
      flag_next[`RTCW_F_OF] = 1'b0;
    end
    flag_next = flag_next | ev;
  end

  // status: write one to clear, set still wins
  always @* begin
    istat_next = istat_reg;
    if (wr_en && wa == `RTCW_A_ISTAT) begin
      istat_next = istat_next & ~hwdata_i[`RTCW_NFLAG-1:0];
    end
    istat_next = istat_next | ev;
  end

  // first output gathers timer, watchdog, match one, osc
  always @* begin
    interrupt_out_one_next = 1'b0;
    if (ctrl_reg[`RTCW_C_TIE]) begin
      if (ctrl_reg[`RTCW_C_TPUL]) begin
        interrupt_out_one_next = (pcnt_reg != 8'h00);
      end else begin
        interrupt_out_one_next = flag_reg[`RTCW_F_ROLL];
      end
    end
    interrupt_out_one_next = interrupt_out_one_next | wlatch_reg;
    interrupt_out_one_next = interrupt_out_one_next | (flag_reg[`RTCW_F_M1] &
                ctrl_reg[`RTCW_C_M1IE]);
    interrupt_out_one_next = interrupt_out_one_next | (flag_reg[`RTCW_F_OF] &
                ctrl_reg[`RTCW_C_OSCILLATOR_FAIL_IRQ_ENABLE]);
    interrupt_out_two_next = flag_reg[`RTCW_F_M2] &
                ctrl_reg[`RTCW_C_M2IE];
  end

  // test output is blocked by any enabled irq function
  always @* begin
    ft_next = ctrl_reg[`RTCW_C_FT] & ftog_reg &
              ~ctrl_reg[`RTCW_C_TIE] &
              ~ctrl_reg[`RTCW_C_M1IE] &
              ~ctrl_reg[`RTCW_C_M2IE] &
              ~ctrl_reg[`RTCW_C_OSCILLATOR_FAIL_IRQ_ENABLE] &
              ~ctrl_reg[`RTCW_C_SQEN] & ~w_arm;
  end

  // read mux, sampled in the wait cycle after the address
  always @* begin
    case (addr_reg)
      `RTCW_A_CTRL:  rdata_next = {18'h0, ctrl_reg};
      `RTCW_A_TIMER: rdata_next = {16'h0, tcnt_reg,
                                   tstart_reg};
      `RTCW_A_WDOG:  rdata_next = {25'h0, wdog_reg};
      `RTCW_A_CAL:   rdata_next = {26'h0, cal_reg};
      `RTCW_A_ALM1:  rdata_next = alm1_reg;
      `RTCW_A_ALM2:  rdata_next = alm2_reg;
      `RTCW_A_FLAGS: rdata_next = {27'h0, flag_reg};
      `RTCW_A_TIME:  rdata_next = time_snap_o;
      `RTCW_A_ISTAT: rdata_next = {27'h0, istat_reg};
      `RTCW_A_IMASK: rdata_next = {27'h0, imask_reg};
      default:       rdata_next = 32'h0;
    endcase
  end

  // ---------------------------------------------------------
  // bus slave: writes land in the data phase, reads wait one
  // ---------------------------------------------------------
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      addr_reg    <= 6'h00;
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      hreadyout_o <= 1'b1;
      hrdata_o    <= 32'h0;
      hresp_o     <= 1'b0;
    end else begin
      wr_pend_reg <= acc & hwrite_i & a_hit;
      rd_pend_reg <= acc & ~hwrite_i;
      if (acc) begin
        // unmapped reads decode to the zero default
        addr_reg <= a_hit ? haddr_i[5:0] : 6'h3C;
      end
      if (acc && !hwrite_i) begin
        hreadyout_o <= 1'b0;
      end else if (rd_pend_reg) begin
        // wait state lets a prior write settle first
        hreadyout_o <= 1'b1;
        hrdata_o    <= rdata_next;
      end
    end
  end

  // ---------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl_reg  <= `RTCW_CTRL_RST;
      cal_reg   <= 6'h00;
      alm1_reg  <= 32'h0;
      alm2_reg  <= 32'h0;
      imask_reg <= {`RTCW_NFLAG{1'b0}};
    end else begin
      if (wr_en && wa == `RTCW_A_CTRL) begin
        ctrl_reg <= hwdata_i[`RTCW_CTRL_W-1:0];
      end
      // power-down wins over a host clear of halt
      if (power_down_i) begin
        ctrl_reg[`RTCW_C_HALT] <= 1'b1;
      end
      if (wr_en && wa == `RTCW_A_CAL) begin
        cal_reg <= hwdata_i[5:0];
      end
      if (wr_en && wa == `RTCW_A_ALM1) begin
        alm1_reg <= hwdata_i;
      end
      if (wr_en && wa == `RTCW_A_ALM2) begin
        alm2_reg <= hwdata_i;
      end
      if (wr_en && wa == `RTCW_A_IMASK) begin
        imask_reg <= hwdata_i[`RTCW_NFLAG-1:0];
      end
    end
  end

  // ---------------------------------------------------------
  // countdown timer
  // ---------------------------------------------------------
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tstart_reg <= 8'h00;
      tcnt_reg   <= 8'h00;
      pcnt_reg   <= 8'h00;
    end else begin
      if (wr_en && wa == `RTCW_A_TIMER) begin
        tstart_reg <= hwdata_i[7:0];
        tcnt_reg   <= hwdata_i[7:0];
      end else if (!ctrl_reg[`RTCW_C_TRUN]) begin
        tcnt_reg <= tstart_reg;
      end else if (t_tick) begin
        // a zero start value never reaches 1
        if (tcnt_reg == 8'h01) begin
          tcnt_reg <= tstart_reg;
        end else if (tcnt_reg != 8'h00) begin
          tcnt_reg <= tcnt_reg - 8'h01;
        end
      end
      // pulse mode: fixed-width strobe per rollover
      if (roll) begin
        pcnt_reg <= PULSE_CYC[7:0];
      end else if (pcnt_reg != 8'h00) begin
        pcnt_reg <= pcnt_reg - 8'h01;
      end
    end
  end

  // ---------------------------------------------------------
  // watchdog
  // ---------------------------------------------------------
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wdog_reg   <= 7'h00;
      wcnt_reg   <= 5'h00;
      wlatch_reg <= 1'b0;
    end else begin
      if (w_wr) begin
        // writing rearms and releases; a same-cycle expiry wins
        wdog_reg   <= hwdata_i[6:0];
        wcnt_reg   <= hwdata_i[`RTCW_W_MULT];
        wlatch_reg <= w_exp;
      end else begin
        if (w_arm && w_tick) begin
          if (wcnt_reg == 5'h01) begin
            // one-shot: stays expired until rewritten
            wdog_reg[`RTCW_W_MULT] <= 5'h00;
            wcnt_reg <= 5'h00;
          end else begin
            wcnt_reg <= wcnt_reg - 5'h01;
          end
        end
        if (w_exp) begin
          wlatch_reg <= 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------
  // flags, status and match history
  // ---------------------------------------------------------
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      flag_reg    <= {`RTCW_NFLAG{1'b0}};
      istat_reg   <= {`RTCW_NFLAG{1'b0}};
      m1_prev_reg <= 1'b0;
      m2_prev_reg <= 1'b0;
    end else begin
      flag_reg    <= flag_next;
      istat_reg   <= istat_next;
      m1_prev_reg <= m1_now;
      m2_prev_reg <= m2_now;
    end
  end

  // ---------------------------------------------------------
  // outputs
  // ---------------------------------------------------------
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      time_snap_o            <= 32'h0;
      time_halt_o            <= 1'b1;
      cal_mag_o              <= 5'h00;
      cal_neg_o              <= 1'b0;
      sqw_o                  <= 1'b0;
      ftog_reg               <= 1'b0;
      freq_test_o            <= 1'b0;
      interrupt_out_one_o    <= 1'b0;
      interrupt_out_one_oe_o <= 1'b0;
      interrupt_out_two_o    <= 1'b0;
      interrupt_out_two_oe_o <= 1'b0;
      irq_o                  <= 1'b0;
    end else begin
      // readable time frozen while halt is set
      if (!ctrl_reg[`RTCW_C_HALT]) begin
        time_snap_o <= time_i;
      end
      time_halt_o <= ctrl_reg[`RTCW_C_HALT];
      cal_mag_o   <= cal_reg[`RTCW_K_MAG];
      cal_neg_o   <= cal_reg[`RTCW_K_SIGN];
      if (!ctrl_reg[`RTCW_C_SQEN]) begin
        sqw_o <= 1'b0;
      end else if (s_tick) begin
        sqw_o <= ~sqw_o;
      end
      if (tick_src_i[0]) begin
        ftog_reg <= ~ftog_reg;
      end
      freq_test_o <= ft_next;
      // open drain: data low, enable pulls the wire down
      interrupt_out_one_o    <= 1'b0;
      interrupt_out_one_oe_o <= interrupt_out_one_next;
      interrupt_out_two_o    <= 1'b0;
      interrupt_out_two_oe_o <= interrupt_out_two_next;
      irq_o <= |(istat_next & imask_reg);
    end
  end

endmodule

// ===== rtcw_chk.sv
// ---------------------------------------------
// port-level checker, bound into the top module
// ---------------------------------------------
module rtcw_chk (
  input wire logic        clk_i,
  input wire logic        nrst_i,
  input wire logic        hsel_i,
  input wire logic [1:0]  htrans_i,
  input wire logic        hwrite_i,
  input wire logic        hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic        hreadyout_o,
  input wire logic        hresp_o,
  input wire logic [3:0]  tick_src_i,
  input wire logic        power_down_i,
  input wire logic [31:0] time_snap_o,
  input wire logic        time_halt_o,
  input wire logic        sqw_o,
  input wire logic        freq_test_o,
  input wire logic        interrupt_out_one_o,
  input wire logic        interrupt_out_two_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // write address phase accepted this cycle
  wire wr_take = hsel_i & htrans_i[1] & hready_i & hwrite_i;
  // accepted transfer, split by direction
  sequence s_take;
    hsel_i && htrans_i[1] && hready_i;
  endsequence
  // one wait cycle, then ready again
  sequence s_rd_ans;
    !hreadyout_o ##1 hreadyout_o;
  endsequence
  property p_rd_wait;
    s_take and !hwrite_i |=> s_rd_ans;
  endproperty
  property p_wr_ready;
    s_take and hwrite_i |=> hreadyout_o;
  endproperty
  // read data must not drift between reads
  property p_rdata_hold;
    !$rose(hreadyout_o) |-> $stable(hrdata_o);
  endproperty
  property p_okay;
    hresp_o == 1'b0;
  endproperty
  // open-drain data pins only ever pull low
  property p_od_low;
    !interrupt_out_one_o && !interrupt_out_two_o;
  endproperty
  // halt bit is set at the next edge, its output one edge later
  property p_pdn_halt;
    power_down_i |-> ##2 time_halt_o;
  endproperty
  property p_frozen;
    time_halt_o && $past(time_halt_o) |-> $stable(time_snap_o);
  endproperty
  // rise comes two edges after a tick, or three after a write
  // that enables the test or lifts a blocking function
  property p_ft_tick;
    $rose(freq_test_o) |-> $past(tick_src_i, 2) != 4'h0 ||
                           $past(wr_take, 3);
  endproperty
  property p_sqw_tick;
    $rose(sqw_o) |-> $past(tick_src_i) != 4'h0;
  endproperty
  a_rd_wait: assert property (p_rd_wait)
    else $error("read answer not after one wait");
  a_wr_ready: assert property (p_wr_ready)
    else $error("write data phase stalled");
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data changed outside a read");
  a_okay: assert property (p_okay)
    else $error("response not okay");
  a_od_low: assert property (p_od_low)
    else $error("irq data pin driven high");
  a_pdn_halt: assert property (p_pdn_halt)
    else $error("power down did not set halt");
  a_frozen: assert property (p_frozen)
    else $error("time snapshot moved while halted");
  a_ft_tick: assert property (p_ft_tick)
    else $error("test output rose without tick");
  a_sqw_tick: assert property (p_sqw_tick)
    else $error("square wave rose without tick");
endmodule

bind rtcw_top rtcw_chk u_chk (.clk_i(clk_i), .nrst_i(nrst_i),
  .hsel_i(hsel_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
  .hready_i(hready_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
  .hresp_o(hresp_o), .tick_src_i(tick_src_i),
  .power_down_i(power_down_i), .time_snap_o(time_snap_o),
  .time_halt_o(time_halt_o), .sqw_o(sqw_o), .freq_test_o(freq_test_o),
  .interrupt_out_one_o(interrupt_out_one_o),
  .interrupt_out_two_o(interrupt_out_two_o));

// ===== rtcw_host.sv
// ---------------------------------------------
// host model: single-word bus master
// ---------------------------------------------
module rtcw_host (
  input  wire logic        clk_i,
  input  wire logic        hready_i,
  input  wire logic [31:0] hrdata_i,
  output logic             hsel_o,
  output logic [31:0]      haddr_o,
  output logic [1:0]       htrans_o,
  output logic             hwrite_o,
  output logic [31:0]      hwdata_o,
  output logic             hung_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle bus at time zero
  initial begin
    hsel_o = 1'b1;
    haddr_o = 32'h0;
    htrans_o = 2'h0;
    hwrite_o = 1'b0;
    hwdata_o = 32'h0;
    hung_o = 1'b0;
  end
  // bounded wait for ready; values read are pre-edge samples
  task automatic wait_rdy;
    int n;
    n = 0;
    @(posedge clk_i);
    while (hready_i !== 1'b1 && n < 50) begin
      n++;
      @(posedge clk_i);
    end
    if (n >= 50) hung_o <= 1'b1;
  endtask
  // one transfer; drives the address phase, then hwdata from d in the data phase
  task automatic xfer(input logic w, input logic [31:0] a, d,
                      output logic [31:0] r);
    @(posedge clk_i);
    haddr_o <= a;
    hwrite_o <= w;
    htrans_o <= 2'h2;
    wait_rdy();
    htrans_o <= 2'h0;
    hwdata_o <= d;
    wait_rdy();
    r = hrdata_i;
    // released data lines must not look valid
    hwdata_o <= ~d;
  endtask
endmodule

// ===== tb.sv
`include "rtcw_consts.vh"
// ---------------------------------------------
// self-checking bench
// ---------------------------------------------
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i;
  logic        nrst_i;
  logic        hsel, hwrite, hrdy, hresp, hung;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, tm, snap;
  logic [3:0]  tick;
  logic        pdn, osc, halt, cneg, sqw, ft, io1, oe1, io2, oe2, irq;
  logic [4:0]  cmag;
  int          num_errors;
  int          checked;
  // short pulse so the width check stays cheap
  rtcw_top #(.PULSE_CYC(4)) dut (.clk_i(clk_i), .nrst_i(nrst_i),
    .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hrdy), .hrdata_o(hrdata),
    .hreadyout_o(hrdy), .hresp_o(hresp), .tick_src_i(tick), .time_i(tm),
    .power_down_i(pdn), .osc_fail_i(osc), .time_snap_o(snap),
    .time_halt_o(halt), .cal_mag_o(cmag), .cal_neg_o(cneg), .sqw_o(sqw),
    .freq_test_o(ft), .interrupt_out_one_o(io1),
    .interrupt_out_one_oe_o(oe1), .interrupt_out_two_o(io2),
    .interrupt_out_two_oe_o(oe2), .irq_o(irq));
  rtcw_host host (.clk_i(clk_i), .hready_i(hrdy), .hrdata_i(hrdata),
    .hsel_o(hsel), .haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwrite),
    .hwdata_o(hwdata), .hung_o(hung));
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  task automatic chk(input string nm, input logic [31:0] s, e);
    checked++;
    if (s !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] r;
    host.xfer(1'b1, {26'h0, a}, d, r);
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] e,
                    input string nm);
    logic [31:0] r;
    host.xfer(1'b0, {26'h0, a}, 32'h0, r);
    chk(nm, r, e);
  endtask
  // output regs lag their cause by a cycle
  task automatic st;
    repeat (3) @(posedge clk_i);
  endtask
  // one-cycle strobe on the chosen tick lines
  task automatic tk(input logic [3:0] m);
    @(posedge clk_i);
    tick <= m;
    @(posedge clk_i);
    tick <= 4'h0;
    st();
  endtask
  task automatic t_timer;
    rd(`RTCW_A_CTRL, 32'h80, "ctrl_rst");
    rd(6'h30, 32'h0, "unmapped");
    wr(`RTCW_A_TIMER, 32'h3);
    wr(`RTCW_A_CTRL, 32'h2);
    repeat (4) tk(4'h1);
    rd(`RTCW_A_TIMER, 32'h0303, "stopped");
    wr(`RTCW_A_CTRL, 32'h3);
    tk(4'h1);
    tk(4'h1);
    rd(`RTCW_A_TIMER, 32'h0103, "at_one");
    chk("oe1_early", oe1, 1'b0);
    tk(4'h1);
    rd(`RTCW_A_TIMER, 32'h0303, "reload");
    chk("oe1_roll", oe1, 1'b1);
    rd(`RTCW_A_FLAGS, 32'h1, "roll_flag");
    st();
    chk("oe1_freed", oe1, 1'b0);
    rd(`RTCW_A_FLAGS, 32'h0, "reread");
    // status register path: masked, unmasked, cleared
    chk("irq_masked", irq, 1'b0);
    wr(`RTCW_A_IMASK, 32'h1);
    st();
    chk("irq_on", irq, 1'b1);
    wr(`RTCW_A_ISTAT, 32'h1);
    st();
    chk("irq_off", irq, 1'b0);
    rd(`RTCW_A_ISTAT, 32'h0, "istat_w1c");
  endtask
  task automatic t_pulse;
    wr(`RTCW_A_CTRL, 32'h7);
    repeat (3) tk(4'h1);
    chk("pulse_hi", oe1, 1'b1);
    repeat (6) @(posedge clk_i);
    chk("pulse_lo", oe1, 1'b0);
    rd(`RTCW_A_FLAGS, 32'h1, "pulse_flag");
    wr(`RTCW_A_CTRL, 32'h0);
  endtask
  // multiplier 3 on resolution tick line 1
  task automatic t_wdog;
    wr(`RTCW_A_WDOG, 32'h23);
    tk(4'h2);
    tk(4'h2);
    chk("wdg_early", oe1, 1'b0);
    tk(4'h2);
    chk("wdg_fire", oe1, 1'b1);
    rd(`RTCW_A_FLAGS, 32'h2, "wdg_flag");
    st();
    chk("wdg_held", oe1, 1'b1);
    wr(`RTCW_A_WDOG, 32'h0);
    st();
    chk("wdg_freed", oe1, 1'b0);
    repeat (4) tk(4'h2);
    rd(`RTCW_A_FLAGS, 32'h0, "wdg_off");
  endtask
  task automatic t_match;
    wr(`RTCW_A_ALM1, 32'h1234);
    wr(`RTCW_A_CTRL, 32'h8);
    tm <= 32'h1234;
    st();
    chk("m1_irq", oe1, 1'b1);
    rd(`RTCW_A_FLAGS, 32'h4, "m1_flag");
    st();
    chk("m1_freed", oe1, 1'b0);
    wr(`RTCW_A_ALM2, 32'h55);
    wr(`RTCW_A_CTRL, 32'h20);
    tm <= 32'h55;
    st();
    chk("m2_off", oe2, 1'b0);
    tm <= 32'h100;
    wr(`RTCW_A_CTRL, 32'h30);
    tm <= 32'h55;
    st();
    chk("m2_irq", oe2, 1'b1);
    rd(`RTCW_A_FLAGS, 32'h8, "m2_flag");
    st();
    chk("m2_freed", oe2, 1'b0);
  endtask
  task automatic t_osc;
    wr(`RTCW_A_CTRL, 32'h40);
    osc <= 1'b1;
    @(posedge clk_i);
    osc <= 1'b0;
    st();
    chk("of_irq", oe1, 1'b1);
    rd(`RTCW_A_FLAGS, 32'h10, "of_read1");
    rd(`RTCW_A_FLAGS, 32'h10, "of_read2");
    wr(`RTCW_A_FLAGS, 32'h0);
    rd(`RTCW_A_FLAGS, 32'h0, "of_clear");
    st();
    chk("of_freed", oe1, 1'b0);
  endtask
  task automatic t_misc;
    logic v;
    wr(`RTCW_A_CAL, 32'h3F);
    // outputs follow the register one edge after the write
    st();
    chk("cal_mag", cmag, 5'h1F);
    chk("cal_neg", cneg, 1'b1);
    tm <= 32'h777;
    st();
    chk("snap_live", snap, 32'h777);
    pdn <= 1'b1;
    @(posedge clk_i);
    pdn <= 1'b0;
    tm <= 32'h888;
    st();
    chk("halted", halt, 1'b1);
    chk("snap_frozen", snap, 32'h777);
    // test output only while no irq function or square wave is enabled
    wr(`RTCW_A_CTRL, 32'h100);
    tk(4'h1);
    v = ft;
    tk(4'h1);
    chk("ft_toggle", ft, !v);
    wr(`RTCW_A_CTRL, 32'h102);
    tk(4'h1);
    chk("ft_blocked", ft, 1'b0);
    wr(`RTCW_A_CTRL, 32'hA00);
    tk(4'h4);
    v = sqw;
    tk(4'h4);
    chk("sqw_toggle", sqw, !v);
    wr(`RTCW_A_CTRL, 32'h0);
    st();
    chk("sqw_off", sqw, 1'b0);
  endtask
  task final_report;
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // a stuck bus ends the run
  always @(posedge hung) begin
    num_errors++;
    final_report();
  end
  initial begin
    num_errors = 0;
    checked = 0;
    nrst_i = 1'b0;
    tick = 4'h0;
    tm = 32'h100;
    pdn = 1'b0;
    osc = 1'b0;
    repeat (20) @(posedge clk_i);
    nrst_i <= 1'b1;
    t_timer();
    t_pulse();
    t_wdog();
    t_match();
    t_osc();
    t_misc();
    final_report();
  end
endmodule
